// [inc/i2cpi_map.svh]
// constants of the two-wire slave front end
// Functional notes
// - only 7-bit addresses are matched; 10-bit sequences are never acknowledged.
// - data falling while clock high is a start; a transfer begins.
// - data rising while clock high is a stop; the transfer ends.
// - data changes only while clock low, except start and stop.
// - after start and eight bits, a valid byte is acknowledged low.
// - not-acknowledge means leaving data released in the ninth clock.
// - first byte after start is address plus direction bit in bit 0.
// - upper five address bits fixed, lower two from pins; others refused.
// - low address pin is latched once when reset ends.
// - general call acknowledged only while general call accept is set.
// - invalid location and operation combination gets a not-acknowledge.
// - during nonvolatile write, acknowledge when write conditions are valid.
// - repeated start is detected like a start and readdresses.
// - repeated start collision (low at rise, clock falls early) resets.
// - every stop returns the serial engine to idle.
// - the clock line is never held low; read data is ready at once.
// - off-format transfers, cut by start or stop, are aborted harmlessly.
// - high-speed master code is not acknowledged and enters high speed.
// - high speed survives repeated starts and ends at the next stop.
// - data is captured on each rising edge of the serial clock.
// - high-voltage flag on low address pin marks the current commands.
`ifndef I2CPI_MAP_SVH
`define I2CPI_MAP_SVH
// address byte [7:3] pattern of the high-speed master code
`define I2CPI_HS_CODE 5'h01
`define I2CPI_GC_ADDR 7'h00
`define I2CPI_BYTE_LAST 3'h7
`define I2CPI_CNT_ZERO 3'h0
`define I2CPI_CNT_ONE 3'h1
// value is arbitrary; the real fixed code is set per product
`define I2CPI_DEV_CODE_DEF 5'h1a
`endif

// [inc/i2cpi_pkg.sv]
// types of the two-wire slave front end
package i2cpi_pkg;
  typedef enum logic [3:0] {
    st_idle,
    st_addr,
    st_judge,
    st_ack,
    st_rx,
    st_tx,
    st_mack,
    st_wait,
    st_hsw
  } i2cpi_state_t;
endpackage : i2cpi_pkg

// [rtl/i2cpi_slave.sv]
// two-wire serial slave front end with address match and ack control
`timescale 1ns/1ps
`default_nettype none
`include "i2cpi_map.svh"
module i2cpi_slave import i2cpi_pkg::*; #(
  parameter logic [4:0] DEVICE_CODE = `I2CPI_DEV_CODE_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic address_pin_upper,
  input wire logic address_pin_lower,
  input wire logic high_voltage_cmd_flag,
  input wire logic general_call_accept,
  input wire logic cmd_combo_valid,
  input wire logic nv_busy,
  input wire logic nv_write_ok,
  input wire logic [7:0] tx_data,
  output logic sda_out,
  output logic sda_oe_n,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_first,
  output logic read_mode,
  output logic tx_req,
  output logic gc_active,
  output logic hs_active,
  output logic hv_cmd_active,
  output logic xfer_active,
  output logic abort_evt,
  output logic collision_evt
);

  ////////////////////////////////////////////////////////////////////////
  // link domain: data bit caught on the serial clock itself

  logic link_bit_reg;

  // no reset: read only after a rising edge has been seen
  always_ff @(posedge scl_link_clk) begin
    link_bit_reg <= sda_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // synchronisers into core_clk

  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic bit_s1_reg, bit_s2_reg;
  logic a1_s1_reg, a1_s2_reg;
  logic a0_s1_reg, a0_s2_reg;
  logic hv_s1_reg, hv_s2_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_s1_reg <= 1'h1;
      scl_s2_reg <= 1'h1;
      scl_d_reg <= 1'h1;
      sda_s1_reg <= 1'h1;
      sda_s2_reg <= 1'h1;
      sda_d_reg <= 1'h1;
      bit_s1_reg <= 1'h1;
      bit_s2_reg <= 1'h1;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
      bit_s1_reg <= link_bit_reg;
      bit_s2_reg <= bit_s1_reg;
    end
  end

  // pins must keep moving through reset so the strap is caught at release
  always_ff @(posedge core_clk) begin
    a1_s1_reg <= address_pin_upper;
    a1_s2_reg <= a1_s1_reg;
    a0_s1_reg <= address_pin_lower;
    a0_s2_reg <= a0_s1_reg;
    hv_s1_reg <= high_voltage_cmd_flag;
    hv_s2_reg <= hv_s1_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // bus events from synchronised samples

  logic scl_rise, scl_fall, start_c, stop_c;

  assign scl_rise = scl_s2_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s2_reg & scl_d_reg;
  // data edge while clock stays high
  assign start_c = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  assign stop_c = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

  ////////////////////////////////////////////////////////////////////////
  // strap of the low address pin

  logic rst_d_reg;
  logic a0_lat_reg;

  always_ff @(posedge core_clk) begin
    rst_d_reg <= rst;
  end

  // the pin later carries the high-voltage flag, so freeze it once
  always_ff @(posedge core_clk) begin
    if (rst) begin
      a0_lat_reg <= 1'h0;
    end else if (rst_d_reg) begin
      a0_lat_reg <= a0_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // byte engine

  i2cpi_state_t state_reg;
  logic [2:0] cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_shift_reg;
  logic rise_seen_reg;
  logic is_read_reg;
  logic first_reg;
  logic hs_arm_reg;
  logic [7:0] byte_next;
  logic bit_done;
  logic byte_done;
  logic addr_match;
  logic addr_gc;
  logic addr_hs;
  logic mid_byte;

  // a bit counts only after its own rise, so the start's fall is skipped
  assign bit_done = scl_fall & rise_seen_reg;
  assign byte_next = {shift_reg[6:0], bit_s2_reg};
  assign byte_done = bit_done & (cnt_reg == `I2CPI_BYTE_LAST);
  // 10-bit prefixes never equal the fixed code, so they are refused
  assign addr_match = byte_next[7:1] ==
    {DEVICE_CODE, a1_s2_reg, a0_lat_reg};
  assign addr_gc = (byte_next[7:1] == `I2CPI_GC_ADDR) & ~byte_next[0];
  assign addr_hs = byte_next[7:3] == `I2CPI_HS_CODE;
  // a start or stop here cuts a byte or its acknowledge
  assign mid_byte = (state_reg == st_addr) | (state_reg == st_judge) |
    (state_reg == st_ack) | (state_reg == st_mack) |
    (((state_reg == st_rx) | (state_reg == st_tx)) &
     ((cnt_reg != `I2CPI_CNT_ZERO) | rise_seen_reg));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= st_idle;
      cnt_reg <= `I2CPI_CNT_ZERO;
      shift_reg <= 8'h00;
      rise_seen_reg <= 1'h0;
      is_read_reg <= 1'h0;
      first_reg <= 1'h0;
    end else if (stop_c) begin
      state_reg <= st_idle;
      rise_seen_reg <= 1'h0;
    end else if (start_c) begin
      state_reg <= st_addr;
      cnt_reg <= `I2CPI_CNT_ZERO;
      rise_seen_reg <= 1'h0;
    end else begin
      if (scl_rise) begin
        rise_seen_reg <= 1'h1;
      end else if (scl_fall) begin
        rise_seen_reg <= 1'h0;
      end
      case (state_reg)
        st_addr: begin
          if (bit_done) begin
            shift_reg <= byte_next;
            cnt_reg <= cnt_reg + `I2CPI_CNT_ONE;
          end
          if (byte_done) begin
            is_read_reg <= byte_next[0];
            first_reg <= 1'h1;
            if (addr_hs) begin
              state_reg <= st_hsw;
            end else if (addr_gc & general_call_accept) begin
              state_reg <= st_ack;
            end else if (addr_match) begin
              state_reg <= st_ack;
            end else begin
              state_reg <= st_wait;
            end
          end
        end
        st_rx: begin
          if (bit_done) begin
            shift_reg <= byte_next;
            cnt_reg <= cnt_reg + `I2CPI_CNT_ONE;
          end
          if (byte_done) begin
            state_reg <= st_judge;
          end
        end
        st_judge: begin
          first_reg <= 1'h0;
          // busy store still takes a command that may run beside it
          if (cmd_combo_valid & (~nv_busy | nv_write_ok)) begin
            state_reg <= st_ack;
          end else begin
            state_reg <= st_wait;
          end
        end
        st_ack: begin
          if (bit_done) begin
            cnt_reg <= `I2CPI_CNT_ZERO;
            state_reg <= is_read_reg ? st_tx : st_rx;
          end
        end
        st_tx: begin
          if (bit_done) begin
            cnt_reg <= cnt_reg + `I2CPI_CNT_ONE;
            if (cnt_reg == `I2CPI_BYTE_LAST) begin
              state_reg <= st_mack;
            end
          end
        end
        st_mack: begin
          if (bit_done) begin
            cnt_reg <= `I2CPI_CNT_ZERO;
            // master's not-acknowledge ends the read
            state_reg <= bit_s2_reg ? st_wait : st_tx;
          end
        end
        st_hsw: begin
          // only a repeated start is legal here
          if (hs_arm_reg & scl_rise & ~sda_s2_reg) begin
            state_reg <= st_idle;
          end else if (hs_arm_reg & scl_fall) begin
            state_reg <= st_idle;
          end
        end
        st_wait: begin
          state_reg <= st_wait;
        end
        default: begin
          state_reg <= st_idle;
        end
      endcase
    end
  end

  // arm only once the not-acknowledge clock is over; its own fall is legal
  always_ff @(posedge core_clk) begin
    if (rst | start_c | stop_c | (state_reg != st_hsw)) begin
      hs_arm_reg <= 1'h0;
    end else if (bit_done) begin
      hs_arm_reg <= 1'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst | start_c | stop_c) begin
      collision_evt <= 1'h0;
    end else begin
      collision_evt <= hs_arm_reg & (state_reg == st_hsw) &
        ((scl_rise & ~sda_s2_reg) | scl_fall);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      abort_evt <= 1'h0;
    end else begin
      abort_evt <= (start_c | stop_c) & mid_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit shifter: loaded as the acknowledge clock ends

  logic tx_load;

  // no wait states: the caller's byte is taken the moment it is needed
  assign tx_load = bit_done & is_read_reg &
    ((state_reg == st_ack) | ((state_reg == st_mack) & ~bit_s2_reg));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_shift_reg <= 8'hff;
    end else if (start_c | stop_c) begin
      tx_shift_reg <= 8'hff;
    end else if (tx_load) begin
      tx_shift_reg <= tx_data;
    end else if ((state_reg == st_tx) & bit_done) begin
      tx_shift_reg <= {tx_shift_reg[6:0], 1'h1};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_req <= 1'h0;
    end else begin
      tx_req <= tx_load & ~start_c & ~stop_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data line drive; the clock line has no driver at all

  logic drive_low;

  always_comb begin
    case (state_reg)
      st_ack: drive_low = 1'h1;
      st_tx: drive_low = ~tx_shift_reg[7];
      default: drive_low = 1'h0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sda_oe_n <= 1'h1;
      sda_out <= 1'h0;
    end else begin
      sda_oe_n <= ~drive_low | start_c | stop_c;
      sda_out <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // received bytes and mode flags

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_data <= 8'h00;
      rx_valid <= 1'h0;
      rx_first <= 1'h0;
    end else begin
      rx_valid <= (state_reg == st_rx) & byte_done & ~start_c & ~stop_c;
      if ((state_reg == st_rx) & byte_done) begin
        rx_data <= byte_next;
        rx_first <= first_reg;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst | stop_c) begin
      hs_active <= 1'h0;
    end else if ((state_reg == st_addr) & byte_done & addr_hs &
                 ~start_c) begin
      hs_active <= 1'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst | stop_c | start_c) begin
      gc_active <= 1'h0;
    end else if ((state_reg == st_addr) & byte_done & addr_gc &
                 general_call_accept) begin
      gc_active <= 1'h1;
    end
  end

  // held over repeated starts so a whole command sequence is marked
  always_ff @(posedge core_clk) begin
    if (rst | stop_c) begin
      hv_cmd_active <= 1'h0;
    end else if ((state_reg == st_addr) & byte_done & addr_match &
                 ~start_c) begin
      hv_cmd_active <= hv_s2_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      read_mode <= 1'h0;
      xfer_active <= 1'h0;
    end else begin
      read_mode <= is_read_reg & (state_reg != st_idle);
      xfer_active <= state_reg != st_idle;
    end
  end

endmodule : i2cpi_slave
`default_nettype wire

// [bench/i2cpi_sva.sv]
// concurrent checks on the two-wire slave front end ports
`timescale 1ns/1ps
`default_nettype none
module i2cpi_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic general_call_accept,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic rx_valid,
  input wire logic read_mode,
  input wire logic gc_active,
  input wire logic hs_active,
  input wire logic hv_cmd_active,
  input wire logic xfer_active,
  input wire logic abort_evt,
  input wire logic collision_evt
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  sequence s_stop;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  sequence s_ack_low;
    !sda_oe_n [*4];
  endsequence
  property p_sda_low;
    sda_out == 1'b0 && (xfer_active || sda_oe_n);
  endproperty
  property p_pull_scl_low; $fell(sda_oe_n) |-> !scl_in; endproperty
  property p_stop_idle;
    s_stop |-> ##[2:6] (!xfer_active && !hs_active && !gc_active);
  endproperty
  property p_ack_hold;
    $fell(sda_oe_n) && !read_mode |-> s_ack_low ##[1:20] sda_oe_n;
  endproperty
  property p_hs_nack; $rose(hs_active) |-> sda_oe_n [*8]; endproperty
  property p_abort_pulse; abort_evt |=> !abort_evt; endproperty
  property p_gc_accept; $rose(gc_active) |-> general_call_accept; endproperty
  property p_hv_xfer; hv_cmd_active |-> xfer_active; endproperty
  property p_coll_idle; collision_evt |-> ##[1:2] !xfer_active; endproperty
  property p_rx_pulse; rx_valid |=> !rx_valid; endproperty
  ////////////////////////////////////////
  a_sda_low: assert property (p_sda_low)
    else $error("data driven high or while idle");
  a_pull_scl_low: assert property (p_pull_scl_low)
    else $error("data pulled while clock high");
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not idle");
  a_ack_hold: assert property (p_ack_hold)
    else $error("ack pulse length bad");
  a_hs_nack: assert property (p_hs_nack)
    else $error("master code acknowledged");
  a_abort_pulse: assert property (p_abort_pulse)
    else $error("abort pulse too long");
  a_gc_accept: assert property (p_gc_accept)
    else $error("general call taken while off");
  a_hv_xfer: assert property (p_hv_xfer)
    else $error("hv flag outside transfer");
  a_coll_idle: assert property (p_coll_idle)
    else $error("collision did not idle");
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("rx pulse too long");
endmodule : i2cpi_sva
bind i2cpi_slave i2cpi_sva u_sva (.core_clk, .rst, .scl_in, .sda_in,
  .general_call_accept, .sda_out, .sda_oe_n, .rx_valid, .read_mode,
  .gc_active, .hs_active, .hv_cmd_active, .xfer_active, .abort_evt,
  .collision_evt);
`default_nettype wire

// [bench/i2cpi_bus_master.sv]
// bus master model: makes the serial clock and drives data
`timescale 1ns/1ps
`default_nettype none
module i2cpi_bus_master (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  // low phase stretched so the slave answer fits inside it
  localparam realtime QTR = 62.5;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic start_cond();
    #3.3;
    if (!scl) begin
      #QTR sda_drv = 1'b1;
      #(2*QTR) scl = 1'b1;
    end
    #(2*QTR) sda_drv = 1'b0;
    #(2*QTR) scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    #3.3;
    #QTR sda_drv = 1'b0;
    #(2*QTR) scl = 1'b1;
    #(2*QTR) sda_drv = 1'b1;
    #(2*QTR);
  endtask : stop_cond
  // data set well after the fall so no edge looks like a condition
  task automatic clk_bit(input logic v, output logic s);
    #QTR sda_drv = v;
    #(2*QTR) scl = 1'b1;
    s = sda;
    #QTR scl = 1'b0;
  endtask : clk_bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, ack);
  endtask : send_byte
  // read a byte with data released, then give the master's own ack bit
  task automatic recv_byte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      b[i] = s;
    end
    clk_bit(mack, s);
  endtask : recv_byte
endmodule : i2cpi_bus_master
`default_nettype wire

// [bench/i2cpi_slave_bench.sv]
// self-checking bench of the two-wire slave front end
`timescale 1ns/1ps
`default_nettype none
module i2cpi_slave_bench;
  localparam logic [4:0] DEV = 5'h16; // value is arbitrary
  localparam logic [7:0] MY = {DEV, 2'b11, 1'b0};
  localparam logic [7:0] CORNER [6] = '{MY, 8'h00, 8'h00,
    {DEV, 2'b10, 1'b0}, 8'hf0, {DEV, 2'b01, 1'b0}};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic pin_hi = 1'b1, pin_lo = 1'b1, hv = 1'b0, gca = 1'b0;
  logic combo = 1'b1, busy = 1'b0, wr_ok = 1'b0;
  logic sda_out, sda_oe_n, rx_valid, rx_first, read_mode, gc_active;
  logic hs_active, hv_cmd_active, xfer_active, abort_evt, collision_evt;
  logic [7:0] rx_data, got, a, d, rd;
  logic [7:0] tx_byte = 8'h00;
  logic got_first, ack, tx_req;
  int abort_cnt = 0, coll_cnt = 0, req_cnt = 0, mark = 0;
  int fail_count = 0;
  int num_checks = 0;
  wire scl, sda_drv;
  wire sda = sda_drv & sda_oe_n;
  i2cpi_slave #(.DEVICE_CODE(DEV)) dut (.core_clk, .rst,
    .scl_link_clk(scl), .scl_in(scl), .sda_in(sda),
    .address_pin_upper(pin_hi), .address_pin_lower(pin_lo),
    .high_voltage_cmd_flag(hv), .general_call_accept(gca),
    .cmd_combo_valid(combo), .nv_busy(busy), .nv_write_ok(wr_ok),
    .tx_data(tx_byte), .sda_out, .sda_oe_n, .rx_data, .rx_valid, .rx_first,
    .read_mode, .tx_req, .gc_active, .hs_active, .hv_cmd_active,
    .xfer_active, .abort_evt, .collision_evt);
  i2cpi_bus_master master (.scl, .sda_drv, .sda);
  initial forever #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (rx_valid) begin
      got <= rx_data;
      got_first <= rx_first;
    end
    if (abort_evt) abort_cnt <= abort_cnt + 1;
    if (collision_evt) coll_cnt <= coll_cnt + 1;
    if (tx_req) req_cnt <= req_cnt + 1;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [8:0] seen, exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask : chk
  // 1 means no acknowledge; low pin taken as latched at reset
  function automatic logic exp_nack(input logic [7:0] x);
    if (x[7:3] == 5'h01) return 1'b1;
    if (x == 8'h00) return !gca;
    return x[7:1] != {DEV, pin_hi, 1'b1};
  endfunction : exp_nack
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    #500us;
    fail_count++;
    summarize();
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h2ae6b3df));
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    pin_lo <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      a = (i < 6) ? CORNER[i] : (8'($urandom) & 8'hfe);
      @(posedge core_clk) gca <= i[1];
      @(posedge core_clk);
      master.start_cond();
      master.send_byte(a, ack);
      chk(ack, exp_nack(a), "addr");
      chk(gc_active, a == 8'h00 && gca, "gc");
      master.stop_cond();
    end
    $display("address test done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      @(posedge core_clk) begin
        combo <= 1'($urandom);
        busy <= 1'($urandom);
        wr_ok <= 1'($urandom);
        hv <= 1'($urandom);
      end
      master.start_cond();
      master.send_byte(MY, ack);
      chk(hv_cmd_active, hv, "hv");
      master.send_byte(d, ack);
      chk(ack, !(combo && (!busy || wr_ok)), "cmd");
      chk({got_first, got}, {1'b1, d}, "rx");
      master.stop_cond();
      chk(xfer_active | hv_cmd_active, 1'b0, "idle");
    end
    $display("command test done");
    for (int k = 0; k < 2; k++) begin
      master.start_cond();
      master.send_byte(MY, ack);
      chk(ack, 1'b0, "readdress");
      mark = abort_cnt;
      for (int i = 0; i < 3; i++) master.clk_bit(1'b1, ack);
      if (k == 0) master.start_cond();
      else master.stop_cond();
      repeat (5) @(posedge core_clk);
      chk(abort_cnt > mark, 1'b1, "abort");
    end
    $display("abort test done");
    tx_byte <= 8'($urandom);
    master.start_cond();
    master.send_byte(MY | 8'h01, ack);
    chk({ack, read_mode}, 2'b01, "read addr");
    mark = req_cnt;
    for (int k = 0; k < 2; k++) begin
      master.recv_byte(k[0], rd);
      chk(rd, tx_byte, "read data");
    end
    chk(req_cnt == mark + 2, 1'b1, "tx req");
    master.stop_cond();
    chk(read_mode, 1'b0, "read end");
    $display("read test done");
    master.start_cond();
    master.send_byte(8'h0d, ack);
    chk({ack, hs_active}, 2'b11, "hs code");
    master.start_cond();
    master.send_byte(MY, ack);
    chk({ack, hs_active}, 2'b01, "hs sr");
    master.stop_cond();
    chk(hs_active, 1'b0, "hs stop");
    mark = coll_cnt;
    master.start_cond();
    master.send_byte(8'h0a, ack);
    repeat (5) @(posedge core_clk);
    chk(coll_cnt == mark, 1'b1, "nack clock");
    master.clk_bit(1'b0, ack);
    repeat (5) @(posedge core_clk);
    chk({coll_cnt > mark, xfer_active}, 2'b10, "collision");
    master.stop_cond();
    $display("high speed test done");
    summarize();
  end
endmodule : i2cpi_slave_bench
`default_nettype wire
